// ---- src/windowed_reading_average_filter.sv ----
// Behaviour
// - Average count consecutive conversions once stack is full; count 1..100.
// - Count one averages nothing but still suppresses out-of-window conversions.
// - Out-of-window conversion resets filter and becomes the new initial value.
// - Window 0.01%..10% in 0.01% steps, or zero meaning no window.
// - Voltage, current, resistance window half-width is percent of full scale.
// - Temperature window half-width is percent of sensor maximum reading.
// - Sliding stack is a FIFO; each new conversion evicts oldest, outputs average.
// - Block mode fills stack, outputs one average, then clears the stack.
// - Scanning with sliding type leaves the filter off.
// - While filling after reset flag unsettled and pass readings as not final.
// - Sliding violation outputs reading, preloads all entries, unsettled until count new.
// - Settled status bit 8 set when settled or filter disabled.
// - Separate configuration per each of seven functions, used when selected.
// - Function or range change resets filter and adopts stored configuration.
// - Changes while enabled act at once; while disabled, on next enable.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module windowed_reading_average_filter
   import wraf_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Conversion stream and filtered readings
   input  wire conv_t       conv,
   output rdg_t             rd,
   // Indicators
   output logic             filter_unsettled_indicator,
   output logic             settled_status,
   output logic             irq
);
   typedef struct packed {
      fcfg_t [NFUNC-1:0]        cfg;
      logic [2:0]               func;
      logic [2:0]               csel;
      logic                     scan;
      logic [DW-1:0]            fs;
      logic [DW-1:0]            tmax;
      logic [8:0]               sts;
      logic [8:0]               mask;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic [DEPTH-1:0][DW-1:0] stk;
      logic signed [31:0]       sum;
      logic [6:0]               wptr;
      logic [6:0]               fill;
      logic                     settled;
      logic                     refv;
      logic                     active;
      logic signed [DW-1:0]     rv;
      rdg_t                     rd;
      logic                     unset;
      logic                     slvl;
      logic                     irq;
   } st_t;

   st_t   q;
   st_t   d;
   fcfg_t c;
   logic  viol;
   logic  wr;

   // Signed divide with round to nearest, half away from zero
   function automatic logic [DW-1:0] avg(input logic signed [31:0] s, input logic [6:0] n);
      logic [31:0] m;
      m = s < 0 ? 32'(-s) : 32'(s);
      m = (m + 32'(n >> 1)) / 32'(n);
      return DW'(s < 0 ? -m : m);
   endfunction

   assign wr = psel && penable && q.pready && pwrite;

   always_comb
   begin
      logic signed [DW:0] df;
      logic [31:0]        hw;
      logic [47:0]        base;
      logic signed [31:0] xs;
      logic signed [31:0] bsum;
      logic [6:0]         bfil;
      logic               rst_f;
      logic [8:0]         ev;
      logic [8:0]         clr;
      df    = '0;
      hw    = '0;
      base  = '0;
      bsum  = '0;
      bfil  = '0;
      rst_f = 1'b0;
      ev    = '0;
      clr   = '0;
      d     = q;
      c     = q.cfg[q.func];
      xs    = 32'($signed(conv.data));
      d.rd  = '0;
      // ----------------------------------------
      // Window check
      // ----------------------------------------
      base = 48'(q.func == TEMP_FUNC ? q.tmax : q.fs);
      hw   = 32'((base * 48'(c.win)) / WIN_DEN);
      df   = (DW+1)'($signed(conv.data)) - (DW+1)'(q.rv);
      // Window ignored while scanning; zero window means none
      viol = q.active && q.refv && c.win != '0 && !q.scan &&
             32'(df < 0 ? -df : df) > hw;
      // ----------------------------------------
      // Filter datapath
      // ----------------------------------------
      if (conv.vld)
      begin
         ev[STS_VIOL] = viol;
         if (!q.active)
         begin
            d.rd = '{vld: 1'b1, fin: 1'b1, data: conv.data};
         end
         else if (c.blk)
         begin
            bsum = (viol || !q.refv) ? 32'sd0 : q.sum;
            bfil = (viol || !q.refv) ? 7'd0 : q.fill;
            if (viol || !q.refv)
            begin
               d.settled = 1'b0;
               d.rv      = conv.data;
               d.refv    = 1'b1;
            end
            d.sum  = bsum + xs;
            d.fill = bfil + 7'd1;
            if (d.fill == c.cnt)
            begin
               d.rd      = '{vld: 1'b1, fin: 1'b1, data: avg(d.sum, c.cnt)};
               d.rv      = $signed(avg(d.sum, c.cnt));
               d.settled = 1'b1;
               d.sum     = '0;
               d.fill    = '0;
            end
            else if (!d.settled)
            begin
               d.rd = '{vld: 1'b1, fin: 1'b0, data: conv.data};
            end
         end
         else if (viol || !q.refv)
         begin
            for (int i = 0; i < DEPTH; i++)
            begin
               d.stk[i] = conv.data;
            end
            d.sum     = xs * $signed({25'd0, c.cnt});
            d.wptr    = '0;
            d.fill    = q.refv ? 7'd0 : 7'd1;
            d.settled = d.fill == c.cnt;
            d.rv      = conv.data;
            d.refv    = 1'b1;
            d.rd      = '{vld: 1'b1, fin: d.settled, data: conv.data};
         end
         else
         begin
            d.stk[q.wptr] = conv.data;
            d.sum         = q.sum - 32'($signed(q.stk[q.wptr])) + xs;
            d.wptr        = q.wptr + 7'd1 == c.cnt ? 7'd0 : q.wptr + 7'd1;
            d.fill        = q.fill < c.cnt ? q.fill + 7'd1 : q.fill;
            d.settled     = q.settled || d.fill == c.cnt;
            d.rv          = $signed(avg(d.sum, c.cnt));
            d.rd          = '{vld: 1'b1, fin: d.settled, data: avg(d.sum, c.cnt)};
         end
         if (viol && c.cnt == CNT_MIN)
         begin
            d.rd = '0;
         end
      end
      ev[STS_READ] = d.rd.vld;
      // ----------------------------------------
      // APB slave, one wait state
      // ----------------------------------------
      d.pready = psel && penable && !q.pready;
      if (psel && penable && !q.pready)
      begin
         d.prdata  = '0;
         d.pslverr = paddr[1:0] != 2'b00;
         case (paddr)
            ADDR_CTRL: d.prdata = {28'd0, q.scan, q.func};
            ADDR_CSEL: d.prdata = {29'd0, q.csel};
            ADDR_CFG:  d.prdata = {12'd0, q.cfg[q.csel].win, 1'b0, q.cfg[q.csel].en,
                                   q.cfg[q.csel].blk, q.cfg[q.csel].cnt};
            ADDR_FS:   d.prdata = {8'd0, q.fs};
            ADDR_TMAX: d.prdata = {8'd0, q.tmax};
            ADDR_STS:  d.prdata = {23'd0, q.sts};
            ADDR_MASK: d.prdata = {23'd0, q.mask};
            ADDR_LVL:  d.prdata = {9'd0, q.fill, 7'd0, q.slvl, 6'd0, q.active, q.unset};
            default:   d.pslverr = 1'b1;
         endcase
      end
      if (wr)
      begin
         case (paddr)
            ADDR_CTRL:
            begin
               if (pwdata[2:0] < 3'(NFUNC))
               begin
                  rst_f  = pwdata[2:0] != q.func;
                  d.func = pwdata[2:0];
               end
               d.scan = pwdata[CTRL_SCAN];
            end
            ADDR_CSEL:
            begin
               if (pwdata[2:0] < 3'(NFUNC))
               begin
                  d.csel = pwdata[2:0];
               end
            end
            ADDR_CFG:
            begin
               // Out-of-range count or window is dropped whole
               if (pwdata[6:0] >= CNT_MIN && pwdata[6:0] <= CNT_MAX &&
                   pwdata[CFG_WIN_LSB +: 10] <= WIN_MAX)
               begin
                  d.cfg[q.csel] = '{en: pwdata[CFG_EN], blk: pwdata[CFG_BLK],
                                    win: pwdata[CFG_WIN_LSB +: 10], cnt: pwdata[6:0]};
                  rst_f = q.csel == q.func;
               end
            end
            ADDR_FS:
            begin
               d.fs  = pwdata[DW-1:0];
               rst_f = 1'b1;
            end
            ADDR_TMAX:
            begin
               d.tmax = pwdata[DW-1:0];
               rst_f  = q.func == TEMP_FUNC;
            end
            ADDR_STS:  clr    = pwdata[8:0];
            ADDR_MASK: d.mask = pwdata[8:0];
            default: ;
         endcase
      end
      // ----------------------------------------
      // Enable, filter reset, status
      // ----------------------------------------
      d.active = d.cfg[d.func].en && !(d.scan && !d.cfg[d.func].blk);
      if (rst_f || d.active != q.active)
      begin
         d.refv    = 1'b0;
         d.settled = 1'b0;
         d.sum     = '0;
         d.fill    = '0;
         d.wptr    = '0;
      end
      d.unset = d.active && !d.settled;
      d.slvl  = !d.active || d.settled;
      ev[STS_SETTLED] = d.slvl && !q.slvl;
      // A new event wins over a clear in the same cycle
      d.sts = (q.sts & ~clr) | ev;
      d.irq = |(d.sts & d.mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q      <= '0;
         q.cfg  <= {NFUNC{fcfg_t'{en: 1'b0, blk: 1'b0, win: WIN_RST, cnt: CNT_RST}}};
         q.fs   <= FS_RST;
         q.tmax <= FS_RST;
         q.slvl <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata                     = q.prdata;
   assign pready                     = q.pready;
   assign pslverr                    = q.pslverr;
   assign rd                         = q.rd;
   assign filter_unsettled_indicator = q.unset;
   assign settled_status             = q.slvl;
   assign irq                        = q.irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("APB access not answered after one wait");
   count_range_a: assert property (c.cnt >= CNT_MIN && c.cnt <= CNT_MAX)
      else $error("Active count outside 1 to 100");
   single_suppress_a: assert property (conv.vld && viol && c.cnt == CNT_MIN |=> !rd.vld)
      else $error("Out-of-window conversion passed with count one");
   // A write that resets the filter may land with a final reading still on its way out
   unsettled_final_a: assert property (!$past(wr) && rd.vld && filter_unsettled_indicator |-> !rd.fin)
      else $error("Final reading flagged while unsettled");
   scan_slide_off_a: assert property (q.scan && !q.cfg[q.func].blk
                                      |-> !filter_unsettled_indicator && settled_status)
      else $error("Sliding filter enabled while scanning");
   settle_status_a: assert property (!q.active |-> settled_status)
      else $error("Settled status low while filter off");
   settled_event_a: assert property ($rose(settled_status) |-> q.sts[STS_SETTLED])
      else $error("Settled event not latched");
   func_reset_a: assert property (wr && paddr == ADDR_CTRL && pwdata[2:0] != q.func && pwdata[2:0] < 3'(NFUNC)
                                  |=> !q.settled && q.fill == 7'd0)
      else $error("Function change did not reset filter");
   slide_preload_a: assert property (conv.vld && viol && !c.blk && c.cnt != CNT_MIN && !wr
                                     |=> rd.vld && rd.data == $past(conv.data) && q.fill == 7'd0)
      else $error("Sliding violation not output and preloaded");
   block_clear_a: assert property (conv.vld && q.active && c.blk && q.refv && !viol && !wr &&
                                   q.fill == c.cnt - 7'd1 |=> rd.fin && q.fill == 7'd0 && q.sum == 0)
      else $error("Block average not output or stack not cleared");
endmodule // windowed_reading_average_filter
`default_nettype wire

// ---- src/wraf_pkg.sv ----
package wraf_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CSEL = 8'h04;
   localparam logic [7:0] ADDR_CFG  = 8'h08;
   localparam logic [7:0] ADDR_FS   = 8'h0c;
   localparam logic [7:0] ADDR_TMAX = 8'h10;
   localparam logic [7:0] ADDR_STS  = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam logic [7:0] ADDR_LVL  = 8'h1c;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_SCAN   = 3;
   localparam int CFG_BLK     = 7;
   localparam int CFG_EN      = 8;
   localparam int CFG_WIN_LSB = 10;
   localparam int STS_READ    = 0;
   localparam int STS_VIOL    = 1;
   localparam int STS_SETTLED = 8;
   localparam int LVL_FILL    = 16;
   // ----------------------------------------
   // Sizes, limits and reset values
   // ----------------------------------------
   localparam int          DW        = 24;
   localparam int          NFUNC     = 7;
   localparam int          DEPTH     = 100;
   localparam logic [2:0]  TEMP_FUNC = 3'h6;
   localparam logic [6:0]  CNT_MIN   = 7'h01;
   localparam logic [6:0]  CNT_MAX   = 7'h64;
   localparam logic [9:0]  WIN_MAX   = 10'h3e8;
   localparam logic [47:0] WIN_DEN   = 48'h2710;
   localparam logic [6:0]  CNT_RST   = 7'h0a;
   localparam logic [9:0]  WIN_RST   = 10'h00a;
   localparam logic [23:0] FS_RST    = 24'h7fffff;

   typedef struct packed {
      logic       en;
      logic       blk;
      logic [9:0] win;
      logic [6:0] cnt;
   } fcfg_t;

   typedef struct packed {
      logic          vld;
      logic [DW-1:0] data;
   } conv_t;

   typedef struct packed {
      logic          vld;
      logic          fin;
      logic [DW-1:0] data;
   } rdg_t;
endpackage

// ---- verification/adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_model
   import wraf_pkg::*;
(
   // Clock and request from the bench
   input  wire logic          pclk,
   input  wire logic          req,
   input  wire logic [DW-1:0] val,
   // Conversion stream
   output var  conv_t         conv
);
   logic [DW-1:0] last_q;
   // Idle data flips every cycle so a stale sample never passes for a fresh one
   always_ff @(posedge pclk)
      last_q <= conv.data;
   assign conv = {req, req ? val : ~last_q};
endmodule // adc_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wraf_pkg::*;
   logic          pclk, presetn, psel, penable, pwrite, req;
   logic          pready, pslverr, unset, settled, irq, err;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rdat;
   logic [DW-1:0] val;
   conv_t         conv;
   rdg_t          rd;
   int            error_cnt, comparisons;

   windowed_reading_average_filter i_windowed_reading_average_filter (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv(conv), .rd(rd), .filter_unsettled_indicator(unset), .settled_status(settled), .irq(irq));
   adc_model i_adc_model (.pclk(pclk), .req(req), .val(val), .conv(conv));

   always #20 pclk = ~pclk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // No fixed latency assumed: wait for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Registered answer is read mid-cycle, then taken at the rising edge that ends the access
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      err  = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         error_cnt++;
         report_and_stop();
      end
   endtask

   function automatic logic [25:0] out(input logic f, input logic [23:0] d);
      return {1'b1, f, d};
   endfunction

   // Reading is due one cycle after the conversion; an expected vld of 0 means no output
   task automatic send(input logic [DW-1:0] d, input logic [25:0] e);
      @(posedge pclk);
      req <= 1'b1;
      val <= d;
      @(posedge pclk);
      req <= 1'b0;
      @(negedge pclk);
      if (e[25])
         chk({6'h0, rd}, {6'h0, e});
      else
         chk({31'h0, rd.vld}, 32'h0);
   endtask

   task automatic ind(input logic [31:0] e);
      chk({30'h0, unset, settled}, e);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_off();
      ind(32'h1);
      chk({31'h0, irq}, 32'h0);
      send(24'h123, out(1'b1, 24'h123));
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask

   task automatic sc_sliding();
      apb(1'b1, ADDR_MASK, 32'h2);
      apb(1'b1, ADDR_FS, 32'h3e8);
      apb(1'b1, ADDR_CFG, 32'hfa104);
      send(24'h64, out(1'b0, 24'h64));
      ind(32'h2);
      send(24'h68, out(1'b0, 24'h65));
      send(24'h6c, out(1'b0, 24'h67));
      send(24'h70, out(1'b1, 24'h6a));
      ind(32'h1);
      send(24'h5a, out(1'b1, 24'h68));
      chk({31'h0, irq}, 32'h0);
      send(24'h1f4, out(1'b0, 24'h1f4));
      ind(32'h2);
      chk({31'h0, irq}, 32'h1);
      send(24'h1fe, out(1'b0, 24'h1f7));
      apb(1'b0, ADDR_STS, 32'h0);
      chk(rdat & 32'h2, 32'h2);
      apb(1'b1, ADDR_STS, 32'h2);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic sc_block();
      apb(1'b1, ADDR_CFG, 32'h182);
      send(24'hfffffd, out(1'b0, 24'hfffffd));
      send(24'hfffffc, out(1'b1, 24'hfffffc));
      send(24'h7, 26'h0);
      send(24'h9, out(1'b1, 24'h8));
   endtask

   task automatic sc_count_one();
      apb(1'b1, ADDR_CFG, 32'hfa101);
      send(24'h64, out(1'b1, 24'h64));
      send(24'h190, 26'h0);
      send(24'h19a, out(1'b1, 24'h19a));
   endtask

   task automatic sc_scan();
      apb(1'b1, ADDR_CFG, 32'h104);
      apb(1'b1, ADDR_CTRL, 32'h8);
      send(24'h4d, out(1'b1, 24'h4d));
      ind(32'h1);
   endtask

   // Sensor maximum gives a narrower window than full scale, so 150 must violate
   task automatic sc_temp();
      apb(1'b1, ADDR_CSEL, 32'h6);
      apb(1'b1, ADDR_CFG, 32'hfa102);
      apb(1'b1, ADDR_TMAX, 32'hc8);
      apb(1'b1, ADDR_CTRL, 32'h6);
      send(24'h64, out(1'b0, 24'h64));
      send(24'h96, out(1'b0, 24'h96));
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      pclk        = 1'b0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0;
      req         = 1'b0;
      val         = 24'h0;
      error_cnt   = 0;
      comparisons = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      sc_off();
      sc_sliding();
      sc_block();
      sc_count_one();
      sc_scan();
      sc_temp();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
